/* File: lcd_link_pkg.sv */
// Shared constants and types for the segment LCD command link
package lcd_link_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int SEG_COUNT = 50;
  localparam int COM_COUNT = 4;
  localparam int ADDR_W = 6;

  // ----------------------------------------
  // Link tokens
  // ----------------------------------------
  typedef enum logic [1:0] {
    TOK_BYTE,
    TOK_START,
    TOK_STOP
  } tok_kind_t;

  typedef struct packed {
    tok_kind_t kind;
    logic [7:0] data;
  } tok_t;

  // Host request kinds
  typedef enum logic [1:0] {
    OP_INIT,
    OP_DISP_ON,
    OP_RAM_WRITE,
    OP_DISP_OFF
  } host_op_t;

  // ----------------------------------------
  // Command bytes and fields
  // ----------------------------------------
  localparam logic [7:0] SLAVE_ADDR_BYTE = 8'h7c;
  localparam logic [7:0] SETUP_SOFT_RESET = 8'hea;
  localparam logic [7:0] SETUP_INT_OSC = 8'he9;
  localparam logic [7:0] MODE_DISP_OFF = 8'hc0;
  localparam logic [7:0] MODE_DISP_ON = 8'hc8;
  localparam logic [7:0] DISP_CTL_DEFAULT = 8'hbf;
  localparam logic [7:0] BLINK_OFF = 8'hf0;
  localparam logic [7:0] ALL_PIXEL_NORMAL = 8'hfc;
  localparam logic [7:0] VOL_UPPER_ZERO = 8'he0;
  localparam logic [7:0] VOL_LOWER_ZERO = 8'hf8;
  localparam logic [7:0] ADDR_SET_BASE = 8'h00;
  localparam int CONT_BIT = 7;
  localparam int SETUP_RESET_BIT = 1;
  localparam int SETUP_CLK_BIT = 0;
  localparam int SETUP_ADDR_BIT = 2;
  localparam int MODE_ENABLE_BIT = 3;
  localparam int MODE_BIAS_BIT = 2;
  localparam int SHORT_SEQ_LEN = 3;
  localparam int DISP_ON_SEQ_LEN = 8;

  // Reset values of control state
  localparam logic [1:0] BLINK_RESET = 2'h0;
  localparam logic [1:0] ALL_PIXEL_RESET = 2'h0;
  localparam logic [4:0] VOLUME_RESET = 5'h00;
  localparam logic [4:0] DISP_CTL_RESET = 5'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int POWER_WAIT_US = 100;
  localparam int POWER_WAIT_CYCLES = POWER_WAIT_US * CLK_MHZ;

endpackage

/* File: lcd_link_if.sv */
// Token link between the host controller and the segment driver
`timescale 1ns/1ps
interface lcd_link_if import lcd_link_pkg::*; ();
  logic tok_valid;
  tok_kind_t tok_kind;
  logic [7:0] tok_data;
  logic tok_ready;

  modport host (output tok_valid, output tok_kind, output tok_data, input tok_ready);
  modport dev (input tok_valid, input tok_kind, input tok_data, output tok_ready);
endinterface

/* File: lcd_seg_device.sv */
// Segment driver end: command parser, display RAM and pattern output
`timescale 1ns/1ps

module lcd_seg_device import lcd_link_pkg::*; #(
  parameter int SEGS = SEG_COUNT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link
  lcd_link_if.dev link,
  // Display side
  output logic [SEGS*COM_COUNT-1:0] seg_pattern,
  output logic display_on,
  output logic initialized,
  output logic [1:0] blink_mode,
  output logic [4:0] volume,
  output logic bias_third,
  output logic ext_clock
);

  // ----------------------------------------
  // Two-entry token buffer
  // ----------------------------------------
  tok_t buf_q [2];
  tok_t buf_d [2];
  logic wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;
  tok_t head;

  assign link.tok_ready = (cnt_q != 2'd2);
  assign push = link.tok_valid && link.tok_ready;
  assign head = buf_q[rd_ptr_q];

  // Buffer next state
  always_comb begin
    buf_d = buf_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    cnt_d = cnt_q;
    if (push) begin
      buf_d[wr_ptr_q] = '{kind: link.tok_kind, data: link.tok_data};
      wr_ptr_d = ~wr_ptr_q;
    end
    if (pop) begin
      rd_ptr_d = ~rd_ptr_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  // Buffer registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_q[0] <= '{kind: TOK_BYTE, data: 8'h00};
      buf_q[1] <= '{kind: TOK_BYTE, data: 8'h00};
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      buf_q <= buf_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------
  // Command parser
  // ----------------------------------------
  typedef enum logic [2:0] {
    P_IDLE,
    P_ADDR,
    P_CMD,
    P_DATA,
    P_SKIP
  } parse_state_t;

  parse_state_t state_q, state_d;
  logic [ADDR_W-1:0] ptr_q, ptr_d;
  logic nib_q, nib_d;
  logic addr_hi_q, addr_hi_d;
  logic init_q, init_d;
  logic enable_q, enable_d;
  logic bias_q, bias_d;
  logic ext_clk_q, ext_clk_d;
  logic [1:0] blink_q, blink_d;
  logic [1:0] apctl_q, apctl_d;
  logic [4:0] vol_q, vol_d;
  logic [4:0] disp_ctl_q, disp_ctl_d;
  logic ram_we;
  logic [3:0] ram_wdata;
  logic have;
  logic [7:0] b;

  assign have = (cnt_q != 2'd0);
  assign b = head.data;
  // A data byte holds the head for two cycles, one per nibble
  assign pop = have && !(state_q == P_DATA && head.kind == TOK_BYTE && !nib_q);

  // Parser next state
  always_comb begin
    state_d = state_q;
    ptr_d = ptr_q;
    nib_d = nib_q;
    addr_hi_d = addr_hi_q;
    init_d = init_q;
    enable_d = enable_q;
    bias_d = bias_q;
    ext_clk_d = ext_clk_q;
    blink_d = blink_q;
    apctl_d = apctl_q;
    vol_d = vol_q;
    disp_ctl_d = disp_ctl_q;
    ram_we = 1'b0;
    ram_wdata = 4'h0;
    if (have) begin
      if (head.kind == TOK_START) begin
        state_d = P_ADDR;
        nib_d = 1'b0;
      end else if (head.kind == TOK_STOP) begin
        state_d = P_IDLE;
        nib_d = 1'b0;
      end else begin
        case (state_q)
          P_ADDR: begin
            state_d = (b == SLAVE_ADDR_BYTE) ? P_CMD : P_SKIP;
          end
          P_CMD: begin
            state_d = b[CONT_BIT] ? P_CMD : P_DATA;
            casez (b[6:0])
              7'b1101???: begin
                if (b[SETUP_RESET_BIT]) begin
                  // Soft reset: control state back to defaults, init flag set
                  init_d = 1'b1;
                  enable_d = 1'b0;
                  bias_d = 1'b0;
                  ext_clk_d = 1'b0;
                  blink_d = BLINK_RESET;
                  apctl_d = ALL_PIXEL_RESET;
                  vol_d = VOLUME_RESET;
                  disp_ctl_d = DISP_CTL_RESET;
                  ptr_d = '0;
                  addr_hi_d = 1'b0;
                end else begin
                  ext_clk_d = b[SETUP_CLK_BIT];
                  addr_hi_d = b[SETUP_ADDR_BIT];
                end
              end
              7'b1110???: blink_d = b[1:0];
              7'b1100???: vol_d = {b[2:0], vol_q[1:0]};
              7'b11110??: vol_d = {vol_q[4:2], b[1:0]};
              7'b11111??: apctl_d = b[1:0];
              7'b100????: begin
                enable_d = b[MODE_ENABLE_BIT];
                bias_d = b[MODE_BIAS_BIT];
              end
              7'b01?????: disp_ctl_d = b[4:0];
              7'b00?????: begin
                ptr_d = {addr_hi_q, b[4:0]};
                nib_d = 1'b0;
              end
              default: ;
            endcase
          end
          P_DATA: begin
            // Upper nibble first, then lower, pointer steps per nibble
            ram_we = 1'b1;
            ram_wdata = nib_q ? b[3:0] : b[7:4];
            nib_d = ~nib_q;
            ptr_d = (ptr_q >= ADDR_W'(SEGS - 1)) ? '0 : ptr_q + 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // Parser registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= P_IDLE;
      ptr_q <= '0;
      nib_q <= 1'b0;
      addr_hi_q <= 1'b0;
      init_q <= 1'b0;
      enable_q <= 1'b0;
      bias_q <= 1'b0;
      ext_clk_q <= 1'b0;
      blink_q <= BLINK_RESET;
      apctl_q <= ALL_PIXEL_RESET;
      vol_q <= VOLUME_RESET;
      disp_ctl_q <= DISP_CTL_RESET;
    end else begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      nib_q <= nib_d;
      addr_hi_q <= addr_hi_d;
      init_q <= init_d;
      enable_q <= enable_d;
      bias_q <= bias_d;
      ext_clk_q <= ext_clk_d;
      blink_q <= blink_d;
      apctl_q <= apctl_d;
      vol_q <= vol_d;
      disp_ctl_q <= disp_ctl_d;
    end
  end

  // ----------------------------------------
  // Display RAM, contents undefined until written
  // ----------------------------------------
  logic [COM_COUNT-1:0] ram_q [SEGS];

  // RAM write port, no reset by design
  always_ff @(posedge clk) begin
    if (ram_we && ptr_q < ADDR_W'(SEGS)) begin
      ram_q[ptr_q] <= ram_wdata;
    end
  end

  // ----------------------------------------
  // Pattern output, one nibble per segment
  // ----------------------------------------
  logic [SEGS*COM_COUNT-1:0] pat_q, pat_d;

  generate
    for (genvar s = 0; s < SEGS; s++) begin : g_seg
      // Bit c of address s drives backplane c of segment s
      always_comb begin
        if (!init_q || !enable_q || apctl_q[0]) begin
          pat_d[s*COM_COUNT +: COM_COUNT] = '0;
        end else if (apctl_q[1]) begin
          pat_d[s*COM_COUNT +: COM_COUNT] = '1;
        end else begin
          pat_d[s*COM_COUNT +: COM_COUNT] = ram_q[s];
        end
      end
    end
  endgenerate

  // Pattern register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pat_q <= '0;
    end else begin
      pat_q <= pat_d;
    end
  end

  // Status outputs
  assign seg_pattern = pat_q;
  assign display_on = init_q && enable_q;
  assign initialized = init_q;
  assign blink_mode = blink_q;
  assign volume = vol_q;
  assign bias_third = bias_q;
  assign ext_clock = ext_clk_q;

endmodule // lcd_seg_device

/* File: lcd_seg_host.sv */
// Host end: power-up wait and the four command sequences
`timescale 1ns/1ps
module lcd_seg_host import lcd_link_pkg::*; #(
  parameter int WAIT_CYCLES = POWER_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link
  lcd_link_if.host link,
  // Sequence requests
  input wire logic req_valid,
  input wire host_op_t req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  output logic req_ready,
  // Display data stream for RAM writes
  input wire logic wr_valid,
  input wire logic [7:0] wr_byte,
  input wire logic wr_last,
  output logic wr_ready,
  // Status
  output logic init_done
);

  typedef enum logic [2:0] {
    H_POWER,
    H_PRESTOP,
    H_IDLE,
    H_BYTES,
    H_DATA,
    H_STOP
  } host_state_t;

  // ----------------------------------------
  // Sequence tables
  // ----------------------------------------
  function automatic logic [8:0] seq_byte(host_op_t op, logic [3:0] idx, logic [ADDR_W-1:0] a);
    logic [7:0] v;
    logic last;
    v = SLAVE_ADDR_BYTE;
    last = 1'b0;
    case (op)
      OP_INIT: begin
        case (idx)
          4'h0: v = SLAVE_ADDR_BYTE;
          4'h1: v = SETUP_SOFT_RESET;
          default: v = MODE_DISP_OFF;
        endcase
        last = (idx == 4'(SHORT_SEQ_LEN - 1));
      end
      OP_DISP_ON: begin
        case (idx)
          4'h0: v = SLAVE_ADDR_BYTE;
          4'h1: v = SETUP_INT_OSC;
          4'h2: v = DISP_CTL_DEFAULT;
          4'h3: v = BLINK_OFF;
          4'h4: v = ALL_PIXEL_NORMAL;
          4'h5: v = VOL_UPPER_ZERO;
          4'h6: v = VOL_LOWER_ZERO;
          default: v = MODE_DISP_ON;
        endcase
        last = (idx == 4'(DISP_ON_SEQ_LEN - 1));
      end
      OP_RAM_WRITE: begin
        case (idx)
          4'h0: v = SLAVE_ADDR_BYTE;
          4'h1: v = SETUP_INT_OSC | {5'h00, a[ADDR_W-1], 2'h0};
          default: v = ADDR_SET_BASE | {3'h0, a[4:0]};
        endcase
        last = (idx == 4'(SHORT_SEQ_LEN - 1));
      end
      default: begin
        case (idx)
          4'h0: v = SLAVE_ADDR_BYTE;
          4'h1: v = SETUP_INT_OSC;
          default: v = MODE_DISP_OFF;
        endcase
        last = (idx == 4'(SHORT_SEQ_LEN - 1));
      end
    endcase
    return {last, v};
  endfunction

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  host_state_t state_q, state_d;
  logic [14:0] wait_q, wait_d;
  logic [3:0] idx_q, idx_d;
  host_op_t op_q, op_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic init_q, init_d;
  logic out_valid_q, out_valid_d;
  tok_kind_t out_kind_q, out_kind_d;
  logic [7:0] out_data_q, out_data_d;
  logic advance;
  logic [8:0] sb;

  // Output slot free when empty or being taken this cycle
  assign advance = !out_valid_q || link.tok_ready;
  // Other sequences are held off until the init sequence has run
  assign req_ready = (state_q == H_IDLE) && advance && (init_q || req_op == OP_INIT);
  assign wr_ready = (state_q == H_DATA) && advance;
  assign sb = seq_byte(op_q, idx_q, addr_q);

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    idx_d = idx_q;
    op_d = op_q;
    addr_d = addr_q;
    init_d = init_q;
    out_valid_d = out_valid_q;
    out_kind_d = out_kind_q;
    out_data_d = out_data_q;
    if (advance) begin
      out_valid_d = 1'b0;
      case (state_q)
        H_POWER: begin
          // Power-up settle time before touching the link
          if (wait_q >= 15'(WAIT_CYCLES - 1)) begin
            state_d = H_PRESTOP;
          end else begin
            wait_d = wait_q + 1'b1;
          end
        end
        H_PRESTOP: begin
          out_valid_d = 1'b1;
          out_kind_d = TOK_STOP;
          state_d = H_IDLE;
        end
        H_IDLE: begin
          if (req_valid && req_ready) begin
            out_valid_d = 1'b1;
            out_kind_d = TOK_START;
            op_d = req_op;
            addr_d = req_addr;
            idx_d = 4'h0;
            state_d = H_BYTES;
          end
        end
        H_BYTES: begin
          // Slave address first, then the op's command list
          out_valid_d = 1'b1;
          out_kind_d = TOK_BYTE;
          out_data_d = sb[7:0];
          idx_d = idx_q + 1'b1;
          if (sb[8]) begin
            state_d = (op_q == OP_RAM_WRITE) ? H_DATA : H_STOP;
          end
        end
        H_DATA: begin
          if (wr_valid) begin
            out_valid_d = 1'b1;
            out_kind_d = TOK_BYTE;
            out_data_d = wr_byte;
            if (wr_last) begin
              state_d = H_STOP;
            end
          end
        end
        H_STOP: begin
          out_valid_d = 1'b1;
          out_kind_d = TOK_STOP;
          if (op_q == OP_INIT) begin
            init_d = 1'b1;
          end
          state_d = H_IDLE;
        end
        default: state_d = H_IDLE;
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= H_POWER;
      wait_q <= '0;
      idx_q <= 4'h0;
      op_q <= OP_INIT;
      addr_q <= '0;
      init_q <= 1'b0;
      out_valid_q <= 1'b0;
      out_kind_q <= TOK_STOP;
      out_data_q <= 8'h00;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      idx_q <= idx_d;
      op_q <= op_d;
      addr_q <= addr_d;
      init_q <= init_d;
      out_valid_q <= out_valid_d;
      out_kind_q <= out_kind_d;
      out_data_q <= out_data_d;
    end
  end

  // Link and status outputs
  assign link.tok_valid = out_valid_q;
  assign link.tok_kind = out_kind_q;
  assign link.tok_data = out_data_q;
  assign init_done = init_q;

endmodule // lcd_seg_host

/* File: lcd_link_assertions.sv */
// Protocol checks on the token link between the host and driver ends
`timescale 1ns/1ps
module lcd_link_assertions import lcd_link_pkg::*; #(
  parameter int WAIT_CYCLES = POWER_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link
  input wire logic tok_valid,
  input wire tok_kind_t tok_kind,
  input wire logic [7:0] tok_data,
  input wire logic tok_ready
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic take;
  logic [31:0] cyc_q, cyc_d;
  logic [3:0] takes_q, takes_d;
  logic after_start_q, after_start_d, after_stop_q, after_stop_d;

  // Cycles since reset, tokens taken, kind of last token
  always_comb begin
    take = tok_valid && tok_ready;
    cyc_d = (cyc_q == 32'hffffffff) ? cyc_q : cyc_q + 32'h1;
    takes_d = (take && takes_q != 4'hf) ? takes_q + 4'h1 : takes_q;
    after_start_d = take ? (tok_kind == TOK_START) : after_start_q;
    after_stop_d = take ? (tok_kind == TOK_STOP) : after_stop_q;
  end

  // Registers only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_q <= 32'h0;
      takes_q <= 4'h0;
      after_start_q <= 1'b0;
      after_stop_q <= 1'b0;
    end else begin
      cyc_q <= cyc_d;
      takes_q <= takes_d;
      after_start_q <= after_start_d;
      after_stop_q <= after_stop_d;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  token_held_a: assert property (
    tok_valid && !tok_ready |=> tok_valid && $stable(tok_kind) && $stable(tok_data))
    else $error("link token changed before it was taken");
  valid_drop_a: assert property (
    $fell(tok_valid) |-> $past(tok_ready))
    else $error("link valid dropped without a take");
  power_wait_a: assert property (
    tok_valid |-> cyc_q >= WAIT_CYCLES - 1)
    else $error("link token before the power wait ended");
  first_stop_a: assert property (
    take && takes_q == 4'h0 |-> tok_kind == TOK_STOP)
    else $error("first link token is not a stop");
  stop_start_a: assert property (
    take && after_stop_q |-> tok_kind == TOK_START)
    else $error("stop not followed by a start");
  start_addr_a: assert property (
    take && after_start_q |-> tok_kind == TOK_BYTE && tok_data == SLAVE_ADDR_BYTE)
    else $error("start not followed by the slave address");
  soft_reset_a: assert property (
    take && takes_q == 4'h3 |-> tok_kind == TOK_BYTE && tok_data == SETUP_SOFT_RESET)
    else $error("first command is not the soft reset");
  init_off_a: assert property (
    take && takes_q == 4'h4 |-> tok_data == MODE_DISP_OFF ##[1:8] (take && tok_kind == TOK_STOP))
    else $error("init sequence not closed by mode off and stop");
  ready_back_a: assert property (
    $fell(tok_ready) |-> ##[1:4] tok_ready)
    else $error("link ready stuck low");
endmodule // lcd_link_assertions

/* File: lcd_segment_init_sequencer_tb.sv */
// Bench joining host and driver ends, checking display outputs
`timescale 1ns/1ps
module lcd_segment_init_sequencer_tb;
  import lcd_link_pkg::*;
  localparam int WAIT = 20;
  localparam int NB = SEG_COUNT * COM_COUNT;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk, rst_b, req_valid, req_ready, wr_valid, wr_last, wr_ready, init_done;
  host_op_t req_op;
  logic [ADDR_W-1:0] req_addr;
  logic [7:0] wr_byte;
  logic [NB-1:0] seg_pattern;
  logic display_on, initialized, bias_third, ext_clock;
  logic [1:0] blink_mode;
  logic [4:0] volume;
  logic [3:0] ram [SEG_COUNT];
  logic [31:0] seed;
  int miscompares, check_count, a, n;
  lcd_link_if lcd_link_if_inst ();
  lcd_seg_host #(.WAIT_CYCLES(WAIT)) lcd_seg_host_inst (.clk(clk), .rst_b(rst_b), .link(lcd_link_if_inst.host),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_ready(req_ready), .wr_valid(wr_valid),
    .wr_byte(wr_byte), .wr_last(wr_last), .wr_ready(wr_ready), .init_done(init_done));
  lcd_seg_device #(.SEGS(SEG_COUNT)) lcd_seg_device_inst (.clk(clk), .rst_b(rst_b), .link(lcd_link_if_inst.dev),
    .seg_pattern(seg_pattern), .display_on(display_on), .initialized(initialized), .blink_mode(blink_mode),
    .volume(volume), .bias_third(bias_third), .ext_clock(ext_clock));
  lcd_link_assertions #(.WAIT_CYCLES(WAIT)) lcd_link_assertions_inst (.clk(clk), .rst_b(rst_b),
    .tok_valid(lcd_link_if_inst.tok_valid), .tok_kind(lcd_link_if_inst.tok_kind),
    .tok_data(lcd_link_if_inst.tok_data), .tok_ready(lcd_link_if_inst.tok_ready));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Pattern from the RAM model, blank when off
  function automatic logic [NB-1:0] expect_pat(input logic on);
    logic [NB-1:0] p;
    p = '0;
    for (int s = 0; s < SEG_COUNT; s++)
      for (int c = 0; c < COM_COUNT; c++)
        p[s*COM_COUNT+c] = on & ram[s][c];
    return p;
  endfunction

  task automatic chk_flag(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_vec(input string what, input logic [NB-1:0] exp, input logic [NB-1:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held until taken
  // Waits are bounded by the watchdog, which fails the run
  task automatic do_op(input host_op_t op, input int addr);
    @(posedge clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= addr[ADDR_W-1:0];
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
  endtask

  // Random data bytes, model keeps two nibbles each
  task automatic send_bytes(input int cnt, input int start);
    int p;
    p = start;
    for (int i = 0; i < cnt; i++) begin
      seed = lfsr(seed);
      wr_valid <= 1'b1;
      wr_byte <= seed[7:0];
      wr_last <= (i == cnt - 1);
      ram[p] = seed[7:4];
      ram[(p + 1) % SEG_COUNT] = seed[3:0];
      p = (p + 2) % SEG_COUNT;
      @(negedge clk);
      while (wr_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
    end
    wr_valid <= 1'b0;
  endtask

  // Host idle and driver drained
  task automatic settle();
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    repeat (10) @(negedge clk);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #(5 * 20000);
    miscompares++;
    end_of_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req_op = OP_DISP_ON;
    req_addr = '0;
    wr_valid = 1'b0;
    wr_byte = 8'h00;
    wr_last = 1'b0;
    seed = 32'hb7af2059;
    miscompares = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (WAIT + 10) @(negedge clk) chk_flag("req_ready", 1'b0, req_ready);
    chk_vec("pattern", '0, seg_pattern);
    chk_flag("initialized", 1'b0, initialized);
    $display("test pre_init done");
    do_op(OP_INIT, 0);
    settle();
    chk_flag("init_done", 1'b1, init_done);
    chk_flag("initialized", 1'b1, initialized);
    chk_flag("display_on", 1'b0, display_on);
    chk_vec("settings", '0, NB'({blink_mode, volume, bias_third, ext_clock}));
    $display("test init done");
    do_op(OP_RAM_WRITE, 0);
    send_bytes(SEG_COUNT / 2, 0);
    settle();
    chk_vec("pattern", '0, seg_pattern);
    do_op(OP_DISP_ON, 0);
    settle();
    chk_flag("display_on", 1'b1, display_on);
    chk_vec("pattern", expect_pat(1'b1), seg_pattern);
    $display("test fill done");
    for (int t = 0; t < 8; t++) begin
      seed = lfsr(seed);
      a = (t == 0) ? SEG_COUNT - 1 : (t == 1) ? SEG_COUNT - 2 : seed[15:8] % SEG_COUNT;
      n = 1 + seed[18:16] + ((t == 0) ? 8 : 0);
      do_op(OP_RAM_WRITE, a);
      send_bytes(n, a);
      settle();
      chk_vec("pattern", expect_pat(1'b1), seg_pattern);
    end
    $display("test random writes done");
    do_op(OP_DISP_OFF, 0);
    settle();
    chk_flag("display_on", 1'b0, display_on);
    chk_vec("pattern", '0, seg_pattern);
    do_op(OP_DISP_ON, 0);
    settle();
    chk_vec("pattern", expect_pat(1'b1), seg_pattern);
    $display("test off and on done");
    do_op(OP_INIT, 0);
    settle();
    chk_flag("display_on", 1'b0, display_on);
    chk_vec("pattern", '0, seg_pattern);
    do_op(OP_DISP_ON, 0);
    settle();
    chk_vec("pattern", expect_pat(1'b1), seg_pattern);
    $display("test second init done");
    end_of_test();
  end
endmodule // lcd_segment_init_sequencer_tb
